// ---- vspf_pkg.sv ----
// constants for the vlan and security port filter
package vspf_pkg;
  localparam int NPORT = 8;
  localparam int PW = 3;
  localparam int VT_DEPTH = 4096;
  localparam int N_STAT = 32;
  localparam logic [11:0] VID_RSVD = 12'hfff;
  localparam logic [11:0] VID_ZERO = 12'h000;
  localparam logic [15:0] ETYPE_8021Q = 16'h8100;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SEC_CNT = 8'h04;
  localparam logic [7:0] OFS_BND_CNT = 8'h08;
  localparam logic [7:0] OFS_VT_ADDR = 8'h0c;
  localparam logic [7:0] OFS_VT_DATA = 8'h10;
  localparam logic [7:0] OFS_STAT_SEL = 8'h14;
  localparam logic [7:0] OFS_STAT_CNT = 8'h18;
  localparam logic [2:0] PORT_REGION = 3'h2;
  // control register bits
  localparam int C_SEC_EN = 0;
  localparam int C_SEC_TRAP = 1;
  localparam int C_ING_CHK = 2;
  localparam int C_EG_CHK = 3;
  localparam int C_MC_TUN = 4;
  localparam int C_UC_TUN = 5;
  localparam int C_SHARED = 6;
  localparam int C_IRQ_EN = 7;
  localparam int C_OTYPE = 16;
  localparam logic [31:0] CTRL_RST = 32'h8100_0000;
  // per-port config fields
  localparam int P_DVID = 0;
  localparam int P_DPRI = 12;
  localparam int P_TMODE = 15;
  localparam int P_DROP_UT = 17;
  localparam int P_DROP_T = 18;
  localparam int P_FORCE_OT = 19;
  localparam int P_GROUP = 24;
  localparam logic [31:0] PCFG_RST = 32'hff00_0001;
  localparam logic [1:0] TM_KEEP = 2'h0;
  localparam logic [1:0] TM_REPLACE = 2'h1;
  localparam logic [1:0] TM_IGNORE = 2'h2;
  // vlan entry fields
  localparam int E_MEMBER = 0;
  localparam int E_ETAG = 8;
  localparam int E_STP = 16;
  localparam logic [1:0] STP_DISABLED = 2'h0;
  localparam logic [1:0] STP_LISTEN = 2'h1;
  localparam logic [1:0] STP_LEARN = 2'h2;
  localparam logic [1:0] STP_FORWARD = 2'h3;
  // stat select fields
  localparam int S_VID = 0;
  localparam int S_IDX = 16;
  localparam int S_EN = 31;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- vspf_filter.sv ----
// vlan, spanning tree and source security filter with axi4-lite registers
// What this block does
// - violation: unknown source or source on wrong port
// - security off: forward, no count, no event
// - security on: drop, count, event, optional trap
// - untagged frames take port default vid, priority
// - tagged: keep, replace with defaults, or ignore
// - port policy drops untagged or tagged frames
// - ingress check drops non-member ingress port
// - egress check: static non-member drop, count empties
// - 4096-entry vlan table, entry 4095 reserved
// - no forwarding outside vlan member list except on tunnel bypass
// - egress-tag bit set: leave tagged
// - statistics for up to 32 selected vlans
// - port group limits forwarding, no tag added
// - unknown destination floods only to members, except multicast on multicast tunnel bypass
// - destination is member list and lookup mask, less the source port
// - multicast tunnel skips membership for multicast
// - unicast tunnel skips for locked, shared only
// - force outer tag on every frame of port
// - outer ethertype 8100 untagged, configured if tagged
// - shared: one database; independent: vid, 60-bit key
// - stp states disable, listen, learn, forward
// - per-vlan stp; shared mode uses vlan 0
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
module vspf_filter (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic frm_valid_i,
  input wire logic [2:0] frm_port_i,
  input wire logic frm_tagged_i,
  input wire logic [11:0] frm_vid_i,
  input wire logic [2:0] frm_pri_i,
  input wire logic frm_mcast_i,
  input wire logic frm_bpdu_i,
  input wire logic sa_hit_i,
  input wire logic [2:0] sa_port_i,
  input wire logic da_hit_i,
  input wire logic da_lock_i,
  input wire logic [7:0] da_mask_i,
  output logic res_valid_o,
  output logic res_drop_o,
  output logic res_trap_cpu_o,
  output logic res_learn_o,
  output logic [7:0] res_dmask_o,
  output logic [11:0] res_vid_o,
  output logic [2:0] res_pri_o,
  output logic [7:0] res_tag_mask_o,
  output logic [7:0] res_pad_mask_o,
  output logic res_outer_tag_o,
  output logic [15:0] res_outer_type_o,
  output logic [11:0] res_fid_o,
  output logic res_wide_key_o,
  output logic sec_event_o
);
  localparam int NP = vspf_pkg::NPORT;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [NP-1:0][31:0] pcfg;
    logic [31:0] sec_cnt;
    logic [31:0] bnd_cnt;
    logic [11:0] vt_addr;
    logic [31:0] stat_sel;
    logic [vspf_pkg::N_STAT-1:0][12:0] stat_vid;
    logic [vspf_pkg::N_STAT-1:0][31:0] stat_cnt;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic res_valid;
    logic res_drop;
    logic res_trap;
    logic res_learn;
    logic [7:0] res_dmask;
    logic [11:0] res_vid;
    logic [2:0] res_pri;
    logic [7:0] res_tag;
    logic [7:0] res_pad;
    logic res_ot;
    logic [15:0] res_otype;
    logic [11:0] res_fid;
    logic res_wide;
    logic sec_evt;
  } vspf_state_t;

  vspf_state_t s;
  vspf_state_t next_s;
  // no reset on the table: software must fill it before enabling ports
  logic [31:0] vt_mem [vspf_pkg::VT_DEPTH];
  logic vt_we;
  logic [11:0] vt_wa;
  logic [31:0] vt_wd;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[7:5] == vspf_pkg::PORT_REGION) ||
      (a == vspf_pkg::OFS_CTRL) || (a == vspf_pkg::OFS_SEC_CNT) ||
      (a == vspf_pkg::OFS_BND_CNT) || (a == vspf_pkg::OFS_VT_ADDR) ||
      (a == vspf_pkg::OFS_VT_DATA) || (a == vspf_pkg::OFS_STAT_SEL) ||
      (a == vspf_pkg::OFS_STAT_CNT);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    merge = r;
  endfunction

  // frame classification, all combinational on the request cycle
  logic [31:0] cfg;
  logic shared;
  logic use_tag;
  logic eff_tagged;
  logic [11:0] vid;
  logic [2:0] pri;
  logic [31:0] ent;
  logic [31:0] stp_ent;
  logic [7:0] member;
  logic [1:0] in_st;
  logic [7:0] fwd_ok;
  logic [7:0] self;
  logic sec_viol;
  logic sec_drop;
  logic pol_drop;
  logic ing_drop;
  logic stp_drop;
  logic bypass;
  logic [7:0] memb_mask;
  logic [7:0] dmask;
  logic eg_drop;
  logic bnd_viol;
  logic drop;

  assign cfg = s.pcfg[frm_port_i];
  assign shared = s.ctrl[vspf_pkg::C_SHARED];
  assign use_tag = frm_tagged_i &&
    (cfg[vspf_pkg::P_TMODE +: 2] == vspf_pkg::TM_KEEP);
  assign eff_tagged = frm_tagged_i &&
    (cfg[vspf_pkg::P_TMODE +: 2] != vspf_pkg::TM_IGNORE);
  assign vid = use_tag ? frm_vid_i : cfg[vspf_pkg::P_DVID +: 12];
  assign pri = use_tag ? frm_pri_i : cfg[vspf_pkg::P_DPRI +: 3];
  assign ent = vt_mem[vid];
  assign stp_ent = shared ? vt_mem[vspf_pkg::VID_ZERO] : ent;
  assign member = ent[vspf_pkg::E_MEMBER +: NP];
  assign in_st = stp_ent[vspf_pkg::E_STP + 2*frm_port_i +: 2];
  assign self = 8'h01 << frm_port_i;

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_eg
      // egress side: only forwarding ports may transmit
      assign fwd_ok[gp] =
        stp_ent[vspf_pkg::E_STP + 2*gp +: 2] == vspf_pkg::STP_FORWARD;
    end
  endgenerate

  assign sec_viol = !sa_hit_i || (sa_port_i != frm_port_i);
  assign sec_drop = s.ctrl[vspf_pkg::C_SEC_EN] && sec_viol;
  assign pol_drop = (cfg[vspf_pkg::P_DROP_UT] && !eff_tagged) ||
    (cfg[vspf_pkg::P_DROP_T] && eff_tagged);
  assign ing_drop = s.ctrl[vspf_pkg::C_ING_CHK] && !member[frm_port_i];
  assign stp_drop = (in_st == vspf_pkg::STP_DISABLED) ||
    (in_st != vspf_pkg::STP_FORWARD && !frm_bpdu_i);
  assign bypass = (s.ctrl[vspf_pkg::C_MC_TUN] && frm_mcast_i) ||
    (s.ctrl[vspf_pkg::C_UC_TUN] && shared && !frm_mcast_i &&
     da_hit_i && da_lock_i);
  assign memb_mask = bypass ? 8'hff : member;
  // lookup mask already holds the flood set on a miss
  assign dmask = da_mask_i & memb_mask & fwd_ok & ~self &
    cfg[vspf_pkg::P_GROUP +: NP];
  assign eg_drop = s.ctrl[vspf_pkg::C_EG_CHK] && !bypass && da_hit_i &&
    da_lock_i && ((da_mask_i & ~member) != 8'h00);
  assign bnd_viol = s.ctrl[vspf_pkg::C_EG_CHK] && !bypass &&
    ((da_mask_i & ~self & member) == 8'h00);
  assign drop = sec_drop || pol_drop || ing_drop || stp_drop || eg_drop ||
    (vid == vspf_pkg::VID_RSVD);

  always_comb begin
    logic aw_hs;
    logic w_hs;
    logic wr_fire;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [31:0] rv;
    logic [4:0] si;
    logic [31:0] va;
    next_s = s;
    rv = 32'h0000_0000;
    vt_we = 1'b0;
    vt_wa = s.vt_addr;
    vt_wd = 32'h0000_0000;
    aw_hs = s_axi_awvalid && s_axi_awready;
    w_hs = s_axi_wvalid && s_axi_wready;
    wa = s.aw_got ? s.aw_addr : s_axi_awaddr;
    wd = s.w_got ? s.w_data : s_axi_wdata;
    ws = s.w_got ? s.w_strb : s_axi_wstrb;
    wr_fire = (s.aw_got || aw_hs) && (s.w_got || w_hs);
    si = s.stat_sel[vspf_pkg::S_IDX +: 5];
    va = merge({20'h00000, s.vt_addr}, wd, ws);
    // write channel: address and data taken in either order
    if (aw_hs) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (w_hs) begin
      next_s.w_got = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    // frame result, one cycle after the request
    next_s.res_valid = frm_valid_i;
    next_s.sec_evt = 1'b0;
    if (frm_valid_i) begin
      next_s.res_drop = drop;
      next_s.res_trap = sec_drop && s.ctrl[vspf_pkg::C_SEC_TRAP];
      next_s.res_learn = !sec_drop &&
        (in_st == vspf_pkg::STP_LEARN || in_st == vspf_pkg::STP_FORWARD);
      next_s.res_dmask = drop ? 8'h00 : dmask;
      next_s.res_vid = vid;
      next_s.res_pri = pri;
      next_s.res_tag = ent[vspf_pkg::E_ETAG +: NP];
      // a received tag that is stripped may leave a runt
      next_s.res_pad = frm_tagged_i ? ~ent[vspf_pkg::E_ETAG +: NP] : 8'h00;
      next_s.res_ot = cfg[vspf_pkg::P_FORCE_OT];
      next_s.res_otype = frm_tagged_i ? s.ctrl[vspf_pkg::C_OTYPE +: 16] :
        vspf_pkg::ETYPE_8021Q;
      next_s.res_fid = shared ? vspf_pkg::VID_ZERO : vid;
      next_s.res_wide = !shared;
      if (sec_drop) begin
        next_s.sec_cnt = s.sec_cnt + 32'h0000_0001;
        next_s.sec_evt = s.ctrl[vspf_pkg::C_IRQ_EN];
      end
      if (bnd_viol) begin
        next_s.bnd_cnt = s.bnd_cnt + 32'h0000_0001;
      end
      for (int i = 0; i < vspf_pkg::N_STAT; i++) begin
        if (!drop && s.stat_vid[i] == {1'b1, vid}) begin
          next_s.stat_cnt[i] = s.stat_cnt[i] + 32'h0000_0001;
        end
      end
    end
    // register writes; software wins over a same-cycle count update
    if (wr_fire) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = addr_ok(wa) ? vspf_pkg::RESP_OKAY :
        vspf_pkg::RESP_SLVERR;
      if (wa[7:5] == vspf_pkg::PORT_REGION) begin
        next_s.pcfg[wa[4:2]] = merge(s.pcfg[wa[4:2]], wd, ws);
      end
      case (wa)
        vspf_pkg::OFS_CTRL: next_s.ctrl = merge(s.ctrl, wd, ws);
        vspf_pkg::OFS_SEC_CNT: next_s.sec_cnt = merge(s.sec_cnt, wd, ws);
        vspf_pkg::OFS_BND_CNT: next_s.bnd_cnt = merge(s.bnd_cnt, wd, ws);
        vspf_pkg::OFS_VT_ADDR: begin
          next_s.vt_addr = va[11:0];
        end
        vspf_pkg::OFS_VT_DATA: begin
          // the reserved entry is never written
          vt_we = s.vt_addr != vspf_pkg::VID_RSVD;
          vt_wd = merge(vt_mem[s.vt_addr], wd, ws);
        end
        vspf_pkg::OFS_STAT_SEL: begin
          next_s.stat_sel = merge(s.stat_sel, wd, ws);
          next_s.stat_vid[next_s.stat_sel[vspf_pkg::S_IDX +: 5]] =
            {next_s.stat_sel[vspf_pkg::S_EN],
             next_s.stat_sel[vspf_pkg::S_VID +: 12]};
        end
        vspf_pkg::OFS_STAT_CNT: next_s.stat_cnt[si] = wd;
        default: ;
      endcase
    end
    // read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_araddr[7:5] == vspf_pkg::PORT_REGION) begin
      rv = s.pcfg[s_axi_araddr[4:2]];
    end
    case (s_axi_araddr)
      vspf_pkg::OFS_CTRL: rv = s.ctrl;
      vspf_pkg::OFS_SEC_CNT: rv = s.sec_cnt;
      vspf_pkg::OFS_BND_CNT: rv = s.bnd_cnt;
      vspf_pkg::OFS_VT_ADDR: rv = {20'h00000, s.vt_addr};
      vspf_pkg::OFS_VT_DATA: rv = vt_mem[s.vt_addr];
      vspf_pkg::OFS_STAT_SEL: rv = s.stat_sel;
      vspf_pkg::OFS_STAT_CNT: rv = s.stat_cnt[si];
      default: ;
    endcase
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rv;
      next_s.rresp = addr_ok(s_axi_araddr) ? vspf_pkg::RESP_OKAY :
        vspf_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
      s.ctrl <= vspf_pkg::CTRL_RST;
      s.pcfg <= {NP{vspf_pkg::PCFG_RST}};
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge clock_i) begin
    if (vt_we) begin
      vt_mem[vt_wa] <= vt_wd;
    end
  end

  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready = !s.w_got && !s.bvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign res_valid_o = s.res_valid;
  assign res_drop_o = s.res_drop;
  assign res_trap_cpu_o = s.res_trap;
  assign res_learn_o = s.res_learn;
  assign res_dmask_o = s.res_dmask;
  assign res_vid_o = s.res_vid;
  assign res_pri_o = s.res_pri;
  assign res_tag_mask_o = s.res_tag;
  assign res_pad_mask_o = s.res_pad;
  assign res_outer_tag_o = s.res_ot;
  assign res_outer_type_o = s.res_otype;
  assign res_fid_o = s.res_fid;
  assign res_wide_key_o = s.res_wide;
  assign sec_event_o = s.sec_evt;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  sequence frm_sec_bad;
    frm_valid_i && s.ctrl[vspf_pkg::C_SEC_EN] && !sa_hit_i;
  endsequence
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  sec_drop_a: assert property (frm_sec_bad |=> res_drop_o &&
      res_dmask_o == 8'h00 &&
      sec_event_o == $past(s.ctrl[vspf_pkg::C_IRQ_EN]))
    else $error("security violation not dropped");
  sec_count_a: assert property ((frm_sec_bad and !s.aw_got &&
      !s_axi_awvalid) |=> s.sec_cnt == $past(s.sec_cnt) + 32'h0000_0001)
    else $error("security counter not advanced");
  sec_off_a: assert property (frm_valid_i &&
      !s.ctrl[vspf_pkg::C_SEC_EN] |=> !sec_event_o && !res_trap_cpu_o)
    else $error("event raised with security off");
  member_mask_a: assert property (frm_valid_i && !bypass |=>
      (res_dmask_o & ~$past(member)) == 8'h00)
    else $error("frame sent outside member list");
  rsvd_drop_a: assert property (frm_valid_i &&
      vid == vspf_pkg::VID_RSVD |=> res_valid_o && res_drop_o)
    else $error("reserved vlan frame passed");
  untag_vid_a: assert property (frm_valid_i && !frm_tagged_i |=>
      res_vid_o == $past(cfg[vspf_pkg::P_DVID +: 12]) &&
      res_pri_o == $past(cfg[vspf_pkg::P_DPRI +: 3]))
    else $error("untagged frame lost port defaults");
  outer_type_a: assert property (frm_valid_i && !frm_tagged_i |=>
      res_outer_type_o == vspf_pkg::ETYPE_8021Q)
    else $error("wrong outer ethertype");
  shared_fid_a: assert property (frm_valid_i && shared |=>
      res_fid_o == vspf_pkg::VID_ZERO && !res_wide_key_o)
    else $error("shared mode not on database zero");
  stp_block_a: assert property (frm_valid_i &&
      in_st == vspf_pkg::STP_LISTEN && !frm_bpdu_i |=>
      res_valid_o && res_drop_o && res_dmask_o == 8'h00)
    else $error("listening port passed data frame");
  write_resp_a: assert property (wr_both |=> s_axi_bvalid)
    else $error("write not answered");
endmodule

// ---- vspf_frame_src.sv ----
// model of the ingress parser and lookup feeding frame requests
`timescale 1ns/1ns
module vspf_frame_src (
  input wire logic clock_i,
  output logic frm_valid_o,
  output logic [34:0] frm_bus_o
);
  initial begin
    frm_valid_o = 1'b0;
    frm_bus_o = 35'h0;
  end
  // one-cycle request with all lookup fields valid beside it
  task automatic send(input logic [34:0] f);
    @(posedge clock_i);
    frm_valid_o <= 1'b1;
    frm_bus_o <= f;
    @(posedge clock_i);
    frm_valid_o <= 1'b0;
    // fields are not held after the pulse, so stale values cannot pass
    frm_bus_o <= ~f;
  endtask
endmodule

// ---- vlan_security_port_filter_tb.sv ----
// self-checking bench for the vlan and security port filter
`timescale 1ns/1ns
module vlan_security_port_filter_tb;
  typedef struct packed {
    logic [34:0] f;
    logic dr;
    logic ev;
    logic [7:0] dm;
    logic [11:0] v;
    logic [2:0] p;
    logic [7:0] tm;
  } vspf_row_t;
  logic clock_i, resetn_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, wresp;
  logic res_valid_o, res_drop_o, res_trap_cpu_o, res_learn_o;
  logic res_outer_tag_o, res_wide_key_o, sec_event_o, fv;
  logic [7:0] res_dmask_o, res_tag_mask_o, res_pad_mask_o;
  logic [11:0] res_vid_o, res_fid_o;
  logic [2:0] res_pri_o;
  logic [15:0] res_outer_type_o;
  logic [34:0] fb;
  logic [11:0] vt_id [5] = '{12'h0, 12'h1, 12'h5, 12'h6, 12'hfff};
  logic [31:0] vt_dat [5] = '{32'hffff_00ff, 32'hffff_00ff,
    32'hffff_030f, 32'hfff7_00ff, 32'h1234_5678};
  vspf_row_t rows [6];
  int bad_count, compares;

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  vspf_frame_src src_u (.clock_i, .frm_valid_o(fv), .frm_bus_o(fb));

  vspf_filter dut_u (.clock_i, .resetn_i, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .frm_valid_i(fv), .frm_port_i(fb[34:32]),
    .frm_tagged_i(fb[31]), .frm_vid_i(fb[30:19]), .frm_pri_i(fb[18:16]),
    .frm_mcast_i(fb[15]), .frm_bpdu_i(fb[14]), .sa_hit_i(fb[13]),
    .sa_port_i(fb[12:10]), .da_hit_i(fb[9]), .da_lock_i(fb[8]),
    .da_mask_i(fb[7:0]), .res_valid_o, .res_drop_o, .res_trap_cpu_o,
    .res_learn_o, .res_dmask_o, .res_vid_o, .res_pri_o, .res_tag_mask_o,
    .res_pad_mask_o, .res_outer_tag_o, .res_outer_type_o, .res_fid_o,
    .res_wide_key_o, .sec_event_o);

  task automatic tally_and_finish;
    $display("compares %0d bad %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("BAD t=%0t seen %h want %h", $time, s, e);
    end
  endtask

  task automatic hang;
    bad_count++;
    $display("BAD t=%0t bus answer missing", $time);
    tally_and_finish();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n > 50) hang();
    end while (!(s_axi_bvalid && s_axi_bready));
    wresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    @(posedge clock_i);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n > 50) hang();
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // result is registered one cycle after the request edge
  task automatic snd(input logic [34:0] f);
    src_u.send(f);
    #1;
    chk(res_valid_o, 1'b1);
  endtask

  function automatic logic [34:0] mk(input int p, t, v, pr, mc, sh, sp,
                                     dh, dl, dm);
    return {p[2:0], t[0], v[11:0], pr[2:0], mc[0], 1'b0, sh[0], sp[2:0],
            dh[0], dl[0], dm[7:0]};
  endfunction

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [34:0] pu2;
    int k;
    {resetn_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    pu2 = mk(2, 0, 0, 0, 0, 1, 2, 0, 0, 'hff);
    rows[0] = '{mk(0, 0, 0, 0, 0, 1, 0, 0, 0, 'hff), 0, 0, 'hfe, 1, 0, 0};
    rows[1] = '{mk(2, 1, 5, 3, 0, 1, 2, 1, 0, 'hff), 0, 0, 'h0b, 5, 3, 3};
    rows[2] = '{mk(3, 0, 0, 0, 0, 0, 0, 0, 0, 'hff), 1, 1, 0, 0, 0, 0};
    rows[3] = '{mk(3, 1, 5, 0, 0, 1, 4, 1, 0, 'hff), 1, 1, 0, 0, 0, 0};
    rows[4] = '{mk(2, 1, 5, 0, 1, 1, 2, 1, 0, 'hf0), 0, 0, 0, 0, 0, 0};
    rows[5] = '{mk(1, 0, 0, 0, 0, 1, 1, 1, 0, 'h08), 0, 0, 'h08, 1, 0, 0};
    repeat (20) @(posedge clock_i);
    resetn_i <= 1'b1;
    #1;
    chk(res_valid_o, 1'b0);
    chk(s_axi_awready, 1'b1);
    axi_rd(8'h00, d, r);
    chk(d, 32'h8100_0000);
    axi_rd(8'h40, d, r);
    chk(d, 32'hff00_0001);
    axi_rd(8'h30, d, r);
    chk(r, 2'h2);
    chk(d, 32'h0);
    axi_wr(8'h34, 32'h1);
    chk(wresp, 2'h2);
    $display("reset and map test done");
    // the table is not reset, so every entry used is written first
    for (k = 0; k < 5; k++) begin
      axi_wr(8'h0c, {20'h0, vt_id[k]});
      axi_wr(8'h10, vt_dat[k]);
    end
    axi_wr(8'h0c, 32'h5);
    axi_rd(8'h10, d, r);
    chk(d, 32'hffff_030f);
    axi_wr(8'h00, 32'h88a8_0081);
    for (int i = 0; i < 6; i++) begin
      snd(rows[i].f);
      chk(res_drop_o, rows[i].dr);
      chk(sec_event_o, rows[i].ev);
      chk(res_dmask_o, rows[i].dm);
      if (rows[i].dm != 8'h00) begin
        chk(res_vid_o, rows[i].v);
        chk(res_pri_o, rows[i].p);
        chk(res_tag_mask_o, rows[i].tm);
        chk(res_pad_mask_o, rows[i].f[31] ? rows[i].tm ^ 8'hff : 8'h00);
      end
      $display("row %0d done", i);
    end
    axi_rd(8'h04, d, r);
    chk(d, 32'h2);
    axi_wr(8'h00, 32'h88a8_0091);
    snd(rows[4].f);
    chk(res_dmask_o, 8'hf0);
    for (k = 0; k < 2; k++) begin
      axi_wr(8'h00, k ? 32'h88a8_00a1 : 32'h88a8_00e1);
      snd(mk(2, 1, 5, 0, 0, 1, 2, 1, 1, 'hf0));
      chk(res_dmask_o, k ? 8'h00 : 8'hf0);
      chk(res_wide_key_o, k);
      chk(res_fid_o, k ? 12'h5 : 12'h0);
    end
    $display("tunnel test done");
    axi_wr(8'h00, 32'h88a8_0080);
    snd(rows[2].f);
    chk({res_drop_o, sec_event_o}, 2'h0);
    chk(res_dmask_o, 8'hf7);
    axi_rd(8'h04, d, r);
    chk(d, 32'h2);
    axi_wr(8'h00, 32'h88a8_0083);
    snd(rows[2].f);
    chk(res_trap_cpu_o, 1'b1);
    chk({res_drop_o, sec_event_o}, 2'h3);
    axi_wr(8'h00, 32'h88a8_0080);
    $display("security off test done");
    for (k = 0; k < 3; k++) begin
      axi_wr(8'h44, 32'hff00_0001 | (k << 15));
      snd(mk(1, 1, 5, 3, 0, 1, 1, 1, 0, 'hff));
      chk(res_vid_o, k ? 12'h1 : 12'h5);
      chk(res_pri_o, k ? 3'h0 : 3'h3);
    end
    axi_wr(8'h44, 32'hff00_0001);
    for (k = 0; k < 2; k++) begin
      axi_wr(8'h48, k ? 32'hff04_0001 : 32'hff02_0001);
      snd(pu2);
      chk(res_drop_o, !k);
      snd(rows[1].f);
      chk(res_drop_o, k);
    end
    axi_wr(8'h48, 32'hff08_0001);
    for (k = 0; k < 2; k++) begin
      snd(k ? rows[1].f : pu2);
      chk(res_outer_tag_o, 1'b1);
      chk(res_outer_type_o, k ? 16'h88a8 : 16'h8100);
    end
    axi_wr(8'h48, 32'hff00_0001);
    snd(mk(2, 1, 'hfff, 0, 0, 1, 2, 1, 0, 'hff));
    chk(res_drop_o, 1'b1);
    $display("port policy test done");
    // vlan 6 has port 1 listening; shared mode must use vlan 0 instead
    for (k = 0; k < 3; k++) begin
      if (k == 2) axi_wr(8'h00, 32'h88a8_00c0);
      snd(mk(1, 1, 6, 0, 0, 1, 1, 1, 0, 'hff) | (k == 1 ? 35'h4000 : 35'h0));
      chk(res_drop_o, k == 0);
      chk(res_learn_o, k == 2);
    end
    axi_wr(8'h00, 32'h88a8_0084);
    snd(mk(5, 1, 5, 0, 0, 1, 5, 1, 0, 'hff));
    chk(res_drop_o, 1'b1);
    snd(mk(5, 0, 0, 0, 0, 1, 5, 1, 0, 'hff));
    chk(res_drop_o, 1'b0);
    axi_wr(8'h00, 32'h88a8_0088);
    snd(mk(2, 1, 5, 0, 0, 1, 2, 1, 1, 'hf0));
    chk(res_drop_o, 1'b1);
    axi_rd(8'h08, d, r);
    chk(d, 32'h1);
    axi_wr(8'h14, 32'h8003_0005);
    snd(rows[1].f);
    snd(rows[1].f);
    axi_rd(8'h18, d, r);
    chk(d, 32'h2);
    $display("state and count test done");
    // second reset in mid-run: counters and config go back to defaults
    resetn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    #1;
    chk({res_valid_o, s_axi_bvalid, s_axi_rvalid}, 3'h0);
    axi_rd(8'h04, d, r);
    chk(d, 32'h0);
    axi_rd(8'h00, d, r);
    chk(d, 32'h8100_0000);
    axi_rd(8'h48, d, r);
    chk(d, 32'hff00_0001);
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule
